// file: exec_pkg.sv
// Shared constants and types for the decrement-branch and increment execution block
`default_nettype none
package exec_pkg;

  // ---------------------------------------------------------------
  // Opcode encodings
  // ---------------------------------------------------------------
  localparam logic [4:0] OPC_DBNZ_REG = 5'h1B;   // Top five bits, low three select register
  localparam logic [7:0] OPC_DBNZ_DIR = 8'hD5;   // Followed by address and offset bytes
  localparam logic [7:0] OPC_INC_ACC = 8'h04;    // Accumulator form
  localparam logic [7:0] OPC_INC_DIR = 8'h05;    // Followed by one address byte
  localparam logic [6:0] OPC_INC_IND = 7'h03;    // Low bit picks pointer register
  localparam logic [4:0] OPC_INC_REG = 5'h01;    // Low three bits select register
  localparam logic [7:0] OPC_INC_DP16 = 8'hA3;   // Data pointer increment

  // ---------------------------------------------------------------
  // Instruction lengths and machine cycle counts
  // ---------------------------------------------------------------
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [1:0] CYC_1 = 2'h1;
  localparam logic [1:0] CYC_2 = 2'h2;

  // ---------------------------------------------------------------
  // Address map facts
  // ---------------------------------------------------------------
  localparam logic [2:0] BANK_TOP = 3'h0;        // Bank registers live in the lowest 32 bytes
  localparam logic [1:0] PORT_TOP = 2'h2;        // Port latches sit at 80,90,A0,B0
  localparam logic [3:0] PORT_LOW = 4'h0;
  localparam logic [7:0] STATUS_ADDR = 8'hD0;    // Processor status word
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] ONE_WORD = 16'h0001;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned MC_CLKS_DEFAULT = 12;  // Clocks per machine cycle
  localparam int unsigned MC_CLKS_MIN = 6;       // Room for pointer and operand access

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {K_DBNZ, K_INC, K_INC_DP16} kind_e;
  typedef enum logic [1:0] {M_ACC, M_REG, M_DIR, M_IND} mode_e;
  typedef enum logic [2:0] {S_IDLE, S_PTR_WAIT, S_READ_WAIT, S_HOLD} state_e;

  // True when a direct address names an output port latch
  function automatic logic is_port_latch(input logic [7:0] a);
    is_port_latch = (a[7:6] == PORT_TOP) && (a[3:0] == PORT_LOW);
  endfunction : is_port_latch

endpackage : exec_pkg
`default_nettype wire

// file: decode_if.sv
// Carrier between the executor and its opcode decoder
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
  import exec_pkg::*;
  logic [7:0] opcode;   // Byte being decoded
  logic valid;          // Opcode belongs to this family
  kind_e kind;          // Operation
  mode_e mode;          // Operand addressing
  logic [2:0] reg_sel;  // Register or pointer number
  logic [1:0] len;      // Bytes in instruction
  logic [1:0] cycles;   // Machine cycles

  modport dec (input opcode, output valid, kind, mode, reg_sel, len, cycles);
  modport exec (output opcode, input valid, kind, mode, reg_sel, len, cycles);
endinterface : decode_if
`default_nettype wire

// file: instr_decode.sv
// Opcode decoder for the decrement-branch and increment family
`timescale 1ns/1ps
`default_nettype none
module instr_decode
(
  // Decode carrier
  decode_if.dec dif
);
  import exec_pkg::*;

  // ---------------------------------------------------------------
  // Pattern match, no overlap between the encodings
  // ---------------------------------------------------------------
  always_comb
  begin
    dif.valid = 1'b0;
    dif.kind = K_INC;
    dif.mode = M_ACC;
    dif.reg_sel = dif.opcode[2:0];
    dif.len = LEN_1;
    dif.cycles = CYC_1;
    if (dif.opcode[7:3] == OPC_DBNZ_REG)
    begin
      // Register decrement-branch, offset byte follows
      dif.valid = 1'b1;
      dif.kind = K_DBNZ;
      dif.mode = M_REG;
      dif.len = LEN_2;
      dif.cycles = CYC_2;
    end
    else if (dif.opcode == OPC_DBNZ_DIR)
    begin
      // Direct decrement-branch, address then offset
      dif.valid = 1'b1;
      dif.kind = K_DBNZ;
      dif.mode = M_DIR;
      dif.len = LEN_3;
      dif.cycles = CYC_2;
    end
    else if (dif.opcode == OPC_INC_ACC)
    begin
      dif.valid = 1'b1;
    end
    else if (dif.opcode == OPC_INC_DIR)
    begin
      dif.valid = 1'b1;
      dif.mode = M_DIR;
      dif.len = LEN_2;
    end
    else if (dif.opcode[7:1] == OPC_INC_IND)
    begin
      // Only two pointer registers exist
      dif.valid = 1'b1;
      dif.mode = M_IND;
      dif.reg_sel = {2'b00, dif.opcode[0]};
    end
    else if (dif.opcode[7:3] == OPC_INC_REG)
    begin
      dif.valid = 1'b1;
      dif.mode = M_REG;
    end
    else if (dif.opcode == OPC_INC_DP16)
    begin
      dif.valid = 1'b1;
      dif.kind = K_INC_DP16;
      dif.cycles = CYC_2;
    end
  end

endmodule : instr_decode
`default_nettype wire

// file: decrement_branch_increment_exec.sv
// Executor for decrement-and-branch, byte increment and data pointer increment
// How it works
// RULE1: Decrement, write back, branch when nonzero
// RULE2: Zero wraps to all ones, branch taken
// RULE3: No status flag is ever touched
// RULE4: Target is next instruction plus signed offset
// RULE5: Decrement-branch operand is register or direct
// RULE6: Port operands read from output latch
// RULE7: Register decrement-branch: 11011rrr, two bytes, two cycles
// RULE8: Direct decrement-branch: D5, three bytes, two cycles
// RULE9: Increment wraps all ones to zero silently
// RULE10: Increment on accumulator, register, direct, indirect
// RULE11: Direct increment: 05, two bytes, one cycle
// RULE12: Data pointer adds one across sixteen bits
// RULE13: Increment encodings 04, 08+r, 06+i
// RULE14: Data pointer increment A3, two cycles
`timescale 1ns/1ps
`default_nettype none
module decrement_branch_increment_exec
#(
  parameter int unsigned MC_CLKS = exec_pkg::MC_CLKS_DEFAULT  // Clocks per machine cycle
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Instruction issue
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc_in,
  output logic busy,
  output logic reject,
  output logic done,
  // Core state inputs
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] acc_in,
  input wire logic [15:0] dp16_in,
  // Internal data memory, one clock read latency
  output logic [7:0] mem_addr,
  output logic mem_rd,
  output logic mem_latch,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Results to the core
  output logic [7:0] acc_out,
  output logic acc_wr,
  output logic [15:0] dp16_out,
  output logic dp16_wr,
  output logic [15:0] pc_out,
  output logic pc_load,
  output logic branch_taken
);
  import exec_pkg::*;

  // ---------------------------------------------------------------
  // Parameters and checks
  // ---------------------------------------------------------------
  localparam int CNT_W = $clog2(MC_CLKS);
  localparam logic [CNT_W-1:0] CLK_LAST = CNT_W'(MC_CLKS - 1);

  // Memory accesses must finish inside the first machine cycle
  if (MC_CLKS < MC_CLKS_MIN)
  begin : g_bad_mc_clks
    $error("MC_CLKS too small for operand access");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    state_e st;              // Sequencer state
    kind_e kind;             // Latched operation
    mode_e mode;             // Latched addressing
    logic [1:0] cyc;         // Machine cycles of this instruction
    logic [1:0] len;         // Bytes of this instruction
    logic [1:0] mc_cnt;      // Machine cycles completed
    logic [CNT_W-1:0] clk_cnt;  // Divider within the machine cycle
    logic [7:0] addr;        // Operand address
    logic [7:0] rel;         // Relative offset byte
    logic [15:0] pc;         // Address of the instruction
    logic [7:0] acc;         // Accumulator snapshot
    logic [15:0] dp16;       // Data pointer snapshot
    logic taken;             // Branch decision
    logic [7:0] mem_addr;
    logic mem_rd;
    logic mem_latch;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] acc_out;
    logic acc_wr;
    logic [15:0] dp16_out;
    logic dp16_wr;
    logic [15:0] pc_out;
    logic pc_load;
    logic done;
    logic reject;
  } state_s;

  state_s state_reg;  // Registered state
  state_s state_next; // Next state
  decode_if dif ();   // Decoder carrier
  logic tick;         // Machine cycle enable from the divider
  logic [7:0] operand; // Value being modified
  logic [7:0] result;  // Modified value

  // ---------------------------------------------------------------
  // Decoder
  // ---------------------------------------------------------------
  assign dif.opcode = opcode;

  instr_decode u_decode
  (
    .dif (dif)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    // Strobes last one clock
    state_next.mem_rd = 1'b0;
    state_next.mem_latch = 1'b0;
    state_next.mem_wr = 1'b0;
    state_next.acc_wr = 1'b0;
    state_next.dp16_wr = 1'b0;
    state_next.pc_load = 1'b0;
    state_next.done = 1'b0;
    state_next.reject = 1'b0;
    tick = (state_reg.st != S_IDLE) && (state_reg.clk_cnt == CLK_LAST);
    // Source byte: accumulator snapshot or memory read data
    operand = (state_reg.mode == M_ACC) ? state_reg.acc : mem_rdata;
    // Plain 8-bit arithmetic, carry out discarded, no flag path
    if (state_reg.kind == K_DBNZ)
      result = operand - ONE_BYTE; // RULE1 RULE2 RULE3
    else
      result = operand + ONE_BYTE; // RULE9 RULE3
    // Machine cycle divider runs only while executing
    if (state_reg.st != S_IDLE)
    begin
      state_next.clk_cnt = tick ? '0 : CNT_W'(state_reg.clk_cnt + 1'b1);
      if (tick)
        state_next.mc_cnt = state_reg.mc_cnt + 2'h1;
    end
    unique case (state_reg.st)
      S_IDLE:
      begin
        if (start && !dif.valid)
          state_next.reject = 1'b1;
        else if (start)
        begin
          // Latch everything so the issuer may move on
          state_next.kind = dif.kind;
          state_next.mode = dif.mode;
          state_next.cyc = dif.cycles;    // RULE7 RULE8 RULE11 RULE13 RULE14
          state_next.len = dif.len;
          state_next.pc = pc_in;
          state_next.acc = acc_in;
          state_next.dp16 = dp16_in;
          state_next.taken = 1'b0;
          state_next.clk_cnt = '0;
          state_next.mc_cnt = 2'h0;
          // Offset is always the last byte
          state_next.rel = (dif.len == LEN_3) ? byte3 : byte2; // RULE4
          state_next.st = S_READ_WAIT;
          unique case (dif.mode)
            M_REG:
            begin
              // Bank register read
              state_next.addr = {BANK_TOP, bank_sel, dif.reg_sel}; // RULE5 RULE10
              state_next.mem_addr = {BANK_TOP, bank_sel, dif.reg_sel};
              state_next.mem_rd = 1'b1;
            end
            M_DIR:
            begin
              // Port targets answer from the latch, not the pins
              state_next.addr = byte2; // RULE5
              state_next.mem_addr = byte2;
              state_next.mem_rd = 1'b1;
              state_next.mem_latch = is_port_latch(byte2); // RULE6
            end
            M_IND:
            begin
              // Fetch the pointer register first
              state_next.mem_addr = {BANK_TOP, bank_sel, dif.reg_sel}; // RULE10
              state_next.mem_rd = 1'b1;
              state_next.st = S_PTR_WAIT;
            end
            M_ACC:
            begin
              // Accumulator or data pointer, nothing to read
              state_next.addr = ZERO_BYTE;
            end
          endcase
        end
      end
      S_PTR_WAIT:
      begin
        // Pointer value is the operand address
        if (!state_reg.mem_rd)
        begin
          state_next.addr = mem_rdata; // RULE10
          state_next.mem_addr = mem_rdata;
          state_next.mem_rd = 1'b1;
          state_next.st = S_READ_WAIT;
        end
      end
      S_READ_WAIT:
      begin
        // Data lands a clock after the strobe
        if (!state_reg.mem_rd)
        begin
          state_next.st = S_HOLD;
          if (state_reg.kind == K_INC_DP16)
          begin
            // Carry from low byte runs into high byte
            state_next.dp16_out = state_reg.dp16 + ONE_WORD; // RULE12
            state_next.dp16_wr = 1'b1;
          end
          else if (state_reg.mode == M_ACC)
          begin
            state_next.acc_out = result;
            state_next.acc_wr = 1'b1;
          end
          else
          begin
            // Write back to the same location
            state_next.mem_addr = state_reg.addr; // RULE1 RULE9
            state_next.mem_wdata = result;
            state_next.mem_wr = 1'b1;
          end
          // Branch only on a nonzero result
          state_next.taken = (state_reg.kind == K_DBNZ) && (result != ZERO_BYTE); // RULE1 RULE2
        end
      end
      S_HOLD:
      begin
        // Finish on the last machine cycle boundary
        if (tick && (state_reg.mc_cnt == state_reg.cyc - 2'h1))
        begin
          state_next.st = S_IDLE;
          state_next.done = 1'b1;
          state_next.pc_load = 1'b1;
          // Step past the instruction, then add the signed offset
          state_next.pc_out = state_reg.pc + {14'h0000, state_reg.len} +
            (state_reg.taken ? {{8{state_reg.rel[7]}}, state_reg.rel} : 16'h0000); // RULE4
        end
      end
      default:
      begin
        // Three state bits leave illegal codes
        state_next.st = S_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign busy = (state_reg.st != S_IDLE);
  assign reject = state_reg.reject;
  assign done = state_reg.done;
  assign mem_addr = state_reg.mem_addr;
  assign mem_rd = state_reg.mem_rd;
  assign mem_latch = state_reg.mem_latch;
  assign mem_wr = state_reg.mem_wr;
  assign mem_wdata = state_reg.mem_wdata;
  assign acc_out = state_reg.acc_out;
  assign acc_wr = state_reg.acc_wr;
  assign dp16_out = state_reg.dp16_out;
  assign dp16_wr = state_reg.dp16_wr;
  assign pc_out = state_reg.pc_out;
  assign pc_load = state_reg.pc_load;
  assign branch_taken = state_reg.taken;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Clocks since the instruction was taken, for cycle checks only
  logic [15:0] since_start;
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      since_start <= 16'h0000;
    else if (start && !busy)
      since_start <= 16'h0000;
    else
      since_start <= since_start + 16'h0001;
  end

  dbnz_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
    (state_reg.st == S_READ_WAIT && state_reg.kind == K_DBNZ && state_reg.mode != M_ACC && !mem_rd)
    |=> mem_wr && mem_wdata == $past(mem_rdata) - ONE_BYTE && mem_addr == $past(state_reg.addr))
    else $error("decrement write-back wrong");

  dbnz_wrap_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE2
    (mem_wr && state_reg.kind == K_DBNZ && mem_wdata == 8'hFF) |-> branch_taken)
    else $error("wrap to all ones did not branch");

  branch_target_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
    pc_load |-> pc_out == state_reg.pc + {14'h0000, state_reg.len} +
      (branch_taken ? {{8{state_reg.rel[7]}}, state_reg.rel} : 16'h0000))
    else $error("branch target wrong");

  inc_wrap_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
    (state_reg.st == S_READ_WAIT && state_reg.kind == K_INC && state_reg.mode != M_ACC && !mem_rd)
    |=> mem_wr && mem_wdata == $past(mem_rdata) + ONE_BYTE && !branch_taken)
    else $error("increment write-back wrong");

  dp16_carry_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
    dp16_wr |-> dp16_out == state_reg.dp16 + ONE_WORD)
    else $error("data pointer increment wrong");

  port_latch_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
    (mem_rd && state_reg.mode == M_DIR && is_port_latch(mem_addr)) |-> mem_latch)
    else $error("port read not from latch");

  flags_kept_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
    (mem_wr && mem_addr == STATUS_ADDR) |-> state_reg.mode == M_DIR)
    else $error("status word written by side effect");

  dbnz_timing_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE7 RULE8 RULE14
    (done && state_reg.cyc == CYC_2) |-> since_start == 16'(2 * MC_CLKS))
    else $error("two-cycle instruction ended off time");

  inc_timing_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE11 RULE13
    (done && state_reg.cyc == CYC_1) |-> since_start == 16'(MC_CLKS))
    else $error("one-cycle instruction ended off time");

  dbnz_mode_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE5
    (busy && state_reg.kind == K_DBNZ) |-> state_reg.mode inside {M_REG, M_DIR})
    else $error("decrement-branch operand mode illegal");

  ind_target_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE10
    (state_reg.st == S_PTR_WAIT && !mem_rd) |=> mem_rd && mem_addr == $past(mem_rdata))
    else $error("indirect operand address wrong");

endmodule : decrement_branch_increment_exec
`default_nettype wire

// file: data_mem_model.sv
// Behavioural internal data memory answering the executor
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
(
  // Clock
  input wire logic mclk,
  // Requests from the executor
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_latch,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  // Read data, valid the cycle after the strobe
  output logic [7:0] mem_rdata
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem [256]; // Bytes, port output latches included
  logic [7:0] rdata_q = 8'h00; // Read data register
  logic port_hit; // Address names a port latch

  assign port_hit = (mem_addr[7:6] == 2'h2) && (mem_addr[3:0] == 4'h0);
  assign mem_rdata = rdata_q;

  // Answer one clock after a read; pins differ from the latch so a wrong source shows
  always @(posedge mclk)
  begin
    if (mem_rd && port_hit && !mem_latch)
      rdata_q <= ~mem[mem_addr];
    else if (mem_rd)
      rdata_q <= mem[mem_addr];
    else
      rdata_q <= ~rdata_q; // Idle bus never repeats the last byte
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
  end
endmodule : data_mem_model
`default_nettype wire

// file: decrement_branch_increment_exec_tb.sv
// Self-checking bench for the decrement-branch and increment executor
`timescale 1ns/1ps
`default_nettype none
module decrement_branch_increment_exec_tb;
  import exec_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int MC = 6; // Short machine cycle keeps the run brief
  logic mclk = 1'b0;
  logic rstn, start, busy, reject, done, mem_rd, mem_latch, mem_wr;
  logic acc_wr, dp16_wr, pc_load, branch_taken, busy0, got_load;
  logic [7:0] opcode, byte2, byte3, acc_in, mem_addr, mem_wdata, mem_rdata, acc_out;
  logic [7:0] wr_addr;
  logic [15:0] pc_in, dp16_in, dp16_out, pc_out;
  logic [1:0] bank_sel;
  int fails = 0;
  int num_checks = 0;
  int took, wr_cnt, latch_cnt, acc_cnt, dp16_cnt;
  int flag_wr = 0; // Writes aimed at the status byte

  always #2 mclk = ~mclk;

  decrement_branch_increment_exec #(.MC_CLKS(MC)) decrement_branch_increment_exec_inst (
    .mclk(mclk), .rstn(rstn), .start(start), .opcode(opcode), .byte2(byte2),
    .byte3(byte3), .pc_in(pc_in), .busy(busy), .reject(reject), .done(done),
    .bank_sel(bank_sel), .acc_in(acc_in), .dp16_in(dp16_in), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_latch(mem_latch), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .acc_out(acc_out), .acc_wr(acc_wr), .dp16_out(dp16_out),
    .dp16_wr(dp16_wr), .pc_out(pc_out), .pc_load(pc_load), .branch_taken(branch_taken));

  data_mem_model data_mem_model_inst (
    .mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_latch(mem_latch),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // Tally strobes as they are sampled, so short pulses are never missed
  always @(posedge mclk)
  begin
    if (mem_wr === 1'b1)
    begin
      wr_cnt++;
      wr_addr = mem_addr;
      if (mem_addr === STATUS_ADDR)
        flag_wr++;
    end
    if (mem_rd === 1'b1 && mem_latch === 1'b1)
      latch_cnt++;
    if (acc_wr === 1'b1)
      acc_cnt++;
    if (dp16_wr === 1'b1)
      dp16_cnt++;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Branch target: next instruction plus sign-extended offset
  function automatic logic [15:0] tgt(input logic [15:0] pc, input int len,
                                      input logic [7:0] rel);
    tgt = pc + 16'(len) + {{8{rel[7]}}, rel};
  endfunction : tgt

  // Issue one instruction and wait, bounded, for done or reject
  task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
                     input logic [15:0] pc, input logic [1:0] bank, input logic [7:0] acc,
                     input logic [15:0] dp);
    wr_cnt = 0;
    latch_cnt = 0;
    acc_cnt = 0;
    dp16_cnt = 0;
    took = 0;
    @(posedge mclk);
    start <= 1'b1;
    opcode <= op;
    byte2 <= b2;
    byte3 <= b3;
    pc_in <= pc;
    bank_sel <= bank;
    acc_in <= acc;
    dp16_in <= dp;
    @(posedge mclk);
    start <= 1'b0;
    #1;
    busy0 = busy;
    while (took < 40 && done !== 1'b1 && reject !== 1'b1)
    begin
      @(posedge mclk);
      #1;
      took++;
    end
    got_load = pc_load;
  endtask : run

  // Common completion checks: length, busy, counter load, memory writes
  task automatic fin(input int mc, input logic [15:0] pc_exp, input int wrs);
    chk("cycles", 16'(took), 16'(mc * MC));
    chk("busy", {15'h0, busy0}, 16'h0001);
    chk("pc_load", {15'h0, got_load}, 16'h0001);
    chk("pc_out", pc_out, pc_exp);
    chk("writes", 16'(wr_cnt), 16'(wrs));
  endtask : fin

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_dbnz_reg;
    data_mem_model_inst.mem[8'h15] = 8'h03;
    run(8'hDD, 8'hF0, 8'h00, 16'h1000, 2'h2, 8'h00, 16'h0000);
    fin(2, tgt(16'h1000, 2, 8'hF0), 1);
    chk("dbnz_reg_addr", {8'h00, wr_addr}, 16'h0015);
    chk("dbnz_reg_val", {8'h00, data_mem_model_inst.mem[8'h15]}, 16'h0002);
    chk("dbnz_reg_taken", {15'h0, branch_taken}, 16'h0001);
    $display("decrement-branch register form finished");
  endtask : t_dbnz_reg

  task automatic t_dbnz_wrap;
    data_mem_model_inst.mem[8'h40] = 8'h00;
    run(8'hD5, 8'h40, 8'h10, 16'h2000, 2'h0, 8'h00, 16'h0000);
    fin(2, tgt(16'h2000, 3, 8'h10), 1);
    chk("dbnz_wrap_val", {8'h00, data_mem_model_inst.mem[8'h40]}, 16'h00FF);
    chk("dbnz_wrap_taken", {15'h0, branch_taken}, 16'h0001);
    $display("decrement-branch wrap finished");
  endtask : t_dbnz_wrap

  task automatic t_dbnz_last;
    data_mem_model_inst.mem[8'h41] = 8'h01;
    run(8'hD5, 8'h41, 8'h80, 16'h2100, 2'h0, 8'h00, 16'h0000);
    fin(2, 16'h2103, 1);
    chk("dbnz_last_val", {8'h00, data_mem_model_inst.mem[8'h41]}, 16'h0000);
    chk("dbnz_last_taken", {15'h0, branch_taken}, 16'h0000);
    $display("decrement-branch fall-through finished");
  endtask : t_dbnz_last

  task automatic t_dbnz_port;
    data_mem_model_inst.mem[8'h90] = 8'h05;
    run(8'hD5, 8'h90, 8'hFE, 16'h3000, 2'h0, 8'h00, 16'h0000);
    fin(2, tgt(16'h3000, 3, 8'hFE), 1);
    chk("dbnz_port_val", {8'h00, data_mem_model_inst.mem[8'h90]}, 16'h0004);
    chk("dbnz_port_latch", 16'(latch_cnt), 16'h0001);
    $display("decrement-branch port finished");
  endtask : t_dbnz_port

  task automatic t_inc_acc;
    run(8'h04, 8'h00, 8'h00, 16'h4000, 2'h0, 8'hFF, 16'h0000);
    fin(1, 16'h4001, 0);
    chk("inc_acc_val", {8'h00, acc_out}, 16'h0000);
    chk("inc_acc_wr", 16'(acc_cnt), 16'h0001);
    $display("increment accumulator finished");
  endtask : t_inc_acc

  task automatic t_inc_reg;
    data_mem_model_inst.mem[8'h0B] = 8'h7F;
    run(8'h0B, 8'h00, 8'h00, 16'h4100, 2'h1, 8'h00, 16'h0000);
    fin(1, 16'h4101, 1);
    chk("inc_reg_val", {8'h00, data_mem_model_inst.mem[8'h0B]}, 16'h0080);
    $display("increment register finished");
  endtask : t_inc_reg

  task automatic t_inc_dir_port;
    data_mem_model_inst.mem[8'hA0] = 8'hFF;
    run(8'h05, 8'hA0, 8'h00, 16'h4200, 2'h0, 8'h00, 16'h0000);
    fin(1, 16'h4202, 1);
    chk("inc_dir_val", {8'h00, data_mem_model_inst.mem[8'hA0]}, 16'h0000);
    chk("inc_dir_latch", 16'(latch_cnt), 16'h0001);
    $display("increment direct port finished");
  endtask : t_inc_dir_port

  task automatic t_inc_ind;
    data_mem_model_inst.mem[8'h19] = 8'h7E;
    data_mem_model_inst.mem[8'h7E] = 8'h41;
    run(8'h07, 8'h00, 8'h00, 16'h4300, 2'h3, 8'h00, 16'h0000);
    fin(1, 16'h4301, 1);
    chk("inc_ind_addr", {8'h00, wr_addr}, 16'h007E);
    chk("inc_ind_val", {8'h00, data_mem_model_inst.mem[8'h7E]}, 16'h0042);
    $display("increment indirect finished");
  endtask : t_inc_ind

  task automatic t_inc_dp16;
    run(8'hA3, 8'h00, 8'h00, 16'h5000, 2'h0, 8'h00, 16'h12FF);
    fin(2, 16'h5001, 0);
    chk("dp16_carry", dp16_out, 16'h1300);
    chk("dp16_wr", 16'(dp16_cnt), 16'h0001);
    run(8'hA3, 8'h00, 8'h00, 16'h5001, 2'h0, 8'h00, 16'hFFFF);
    chk("dp16_wrap", dp16_out, 16'h0000);
    $display("data pointer increment finished");
  endtask : t_inc_dp16

  // Unknown opcode: refused at once with no write and no completion
  task automatic t_reject;
    run(8'h00, 8'h40, 8'h00, 16'h6000, 2'h0, 8'h00, 16'h0000);
    chk("reject_now", 16'(took), 16'h0000);
    chk("reject_pulse", {15'h0, reject}, 16'h0001);
    repeat (2 * MC + 2) @(posedge mclk);
    chk("reject_writes", 16'(wr_cnt), 16'h0000);
    $display("unknown opcode finished");
  endtask : t_reject

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    start = 1'b0;
    opcode = 8'h00;
    byte2 = 8'h00;
    byte3 = 8'h00;
    pc_in = 16'h0000;
    bank_sel = 2'h0;
    acc_in = 8'h00;
    dp16_in = 16'h0000;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    chk("reset_busy", {15'h0, busy}, 16'h0000);
    t_dbnz_reg();
    t_dbnz_wrap();
    t_dbnz_last();
    t_dbnz_port();
    t_inc_acc();
    t_inc_reg();
    t_inc_dir_port();
    t_inc_ind();
    t_inc_dp16();
    t_reject();
    chk("status_writes", 16'(flag_wr), 16'h0000);
    stop_test();
  end

  // About 134 cycles expected; cut off well beyond
  initial
  begin
    #8000;
    fails++;
    stop_test();
  end
endmodule : decrement_branch_increment_exec_tb
`default_nettype wire
